// ===== shared/rdd_pkg.sv
// Purpose: constants and types of the radio data decoder register set
// Assumes: byte-wide register transfers, block words of 16 bits
// Notes: field layouts are the packed struct orders, msb first
package rdd_pkg;

    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // register pointers
    // ----------------------------------------------------------------
    localparam logic [1:0] WR_MODE = 2'h0;
    localparam logic [1:0] WR_PAUSE = 2'h1;
    localparam logic [1:0] WR_OSC = 2'h2;
    localparam logic [1:0] WR_END = 2'h3;
    localparam logic [1:0] WR_STEP = 2'h1;

    localparam logic [2:0] RD_STATUS = 3'h0;
    localparam logic [2:0] RD_LAST_HI = 3'h1;
    localparam logic [2:0] RD_LAST_LO = 3'h2;
    localparam logic [2:0] RD_PREV_HI = 3'h3;
    localparam logic [2:0] RD_PREV_LO = 3'h4;
    localparam logic [2:0] RD_ERRORS = 3'h5;
    localparam logic [2:0] RD_QUALITY = 3'h6;
    localparam logic [2:0] RD_END = 3'h7;
    localparam logic [2:0] RD_STEP = 3'h1;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] BLK_A = 3'h0;
    localparam logic [2:0] BLK_B = 3'h1;
    localparam logic [2:0] BLK_C = 3'h2;
    localparam logic [2:0] BLK_D = 3'h3;
    localparam logic [2:0] BLK_C_PRIME = 3'h4;
    localparam logic [2:0] BLK_E_US = 3'h5;
    localparam logic [2:0] BLK_E_BAD = 3'h6;
    localparam logic [2:0] BLK_INVALID = 3'h7;

    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_FIXED_TWO = 2'h1;
    localparam logic [1:0] ERR_FIXED_FIVE = 2'h2;
    localparam logic [1:0] ERR_UNCORRECTABLE = 2'h3;

    localparam logic [1:0] SEARCH_NO_CORRECTION = 2'h0;
    localparam logic [1:0] SEARCH_FIX_TWO_BIT = 2'h1;
    localparam logic [1:0] SEARCH_FIX_FIVE_BIT = 2'h2;
    localparam logic [1:0] SEARCH_STRICT_SEQUENCE = 2'h3;

    localparam logic [1:0] PROTOCOL_STANDARD = 2'h0;
    localparam logic [1:0] PROTOCOL_FAST_ID_SEARCH = 2'h1;
    localparam logic [1:0] PROTOCOL_REDUCED_RATE = 2'h2;

    localparam logic [5:0] ERR_COUNT_MAX = 6'h3F;
    localparam logic [5:0] ERR_COUNT_STEP = 6'h01;

    // ----------------------------------------------------------------
    // write registers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic quality_continuous_sel;
        logic quality_trigger;
        logic sync_restart;
        logic [1:0] search_correction;
        logic us_standard;
        logic [1:0] output_protocol;
    } rdd_mode_t;

    typedef struct packed {
        logic [1:0] pause_level;
        logic [5:0] flywheel_limit;
    } rdd_pause_t;

    typedef struct packed {
        logic [1:0] time_or_osc;
        logic osc_select_meaning;
        logic [4:0] quality_sensitivity;
    } rdd_osc_t;

    localparam rdd_mode_t MODE_RESET = 8'h20;
    localparam rdd_pause_t PAUSE_RESET = 8'h20;
    localparam rdd_osc_t OSC_RESET = 8'h0F;

    // ----------------------------------------------------------------
    // decoded block as delivered by the block detector
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] word;
        logic [2:0] id;
        logic [1:0] err;
    } rdd_block_t;

    localparam int BLOCK_W = $bits(rdd_block_t);

endpackage

// ===== src/rdd_regs.sv
// Purpose: control and status register set of a radio data decoder
// Assumes: a serial framing layer delivers byte strobes on i_clk
// Notes: one 8-word buffer holds detected blocks until the read side is free
//
// Notes on behaviour
// - bit 7 selects triggered or continuous quality
// - bit 6 written one triggers quality measurement
// - bit 5 written one restarts block sync
// - two-bit field selects sync search correction
// - code 11 forbids E-E, US allows E-A
// - bit 2 selects European or US rules
// - protocol 00 ready after every block
// - protocol 01 ready on clean A during search
// - protocol 10 ready every second block
// - pause level and flywheel limit byte
// - bit 5 gives meaning of bits 7:6
// - pause time codes 20.2 to 161.7 ms
// - oscillator codes declare crystal multiple
// - five-bit quality sensitivity in 0.6 dB
// - reset values: resync, flywheel 32, sensitivity 0F
// - status byte layout id, sync, flags, error
// - block identity codes per block type
// - error status codes per correction done
// - overflow flag marks lost block data
// - bytes 1-4 last and previous block words
// - byte 5 error count and previous status
// - byte 6 previous id and quality value
// - reading status byte clears reset flag
// - pointers start at zero, auto-increment
// - block update also takes new mode settings
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// block buffer
// ----------------------------------------------------------------
module rdd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
    // a count, not a pointer compare, tells full from empty

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic push;
    logic pop;

    // wrap by compare, so any depth works, not only powers of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == PTR_LAST) ? '0 : p + AW'(1);
    endfunction

    assign o_ready = (s.cnt != CNT_FULL);
    assign o_valid = (s.cnt != '0);
    assign o_data = s.mem[s.rp];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // push and pop in one cycle leave the count alone
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = i_data;
            next_s.wp = bump(s.wp);
        end
        if (pop) begin
            next_s.rp = bump(s.rp);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + (AW + 1)'(1);
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - (AW + 1)'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // rdd_fifo

// ----------------------------------------------------------------
// register set
// ----------------------------------------------------------------
module rdd_regs
    import rdd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    // write side of the serial framing
    input wire logic i_wr_start,
    input wire logic i_wr_strobe,
    input wire logic [BYTE_W-1:0] i_wr_byte,
    output logic o_wr_ack,
    // read side; i_rd_active spans a whole transfer
    input wire logic i_rd_start,
    input wire logic i_rd_active,
    input wire logic i_rd_strobe,
    output logic [BYTE_W-1:0] o_rd_byte,
    output logic o_rd_valid,
    // decoded blocks from the block detector
    input wire logic i_blk_valid,
    input wire rdd_block_t i_blk,
    output logic o_blk_ready,
    // sync state and quality result, same clock
    input wire logic i_synced,
    input wire logic i_quality_valid,
    input wire logic [3:0] i_quality_value,
    // settings and strobes towards the decoder
    output rdd_mode_t o_mode,
    output rdd_pause_t o_pause,
    output rdd_osc_t o_osc,
    output logic o_quality_trigger,
    output logic o_sync_restart,
    output logic o_data_ready_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        // as written; the decoder only sees mode_act
        rdd_mode_t mode_wr;
        rdd_mode_t mode_act;
        rdd_pause_t pause;
        rdd_osc_t osc;
        logic [1:0] wr_ptr;
        logic [2:0] rd_ptr;
        logic [BYTE_W-1:0] rd_byte;
        logic rd_valid;
        rdd_block_t last;
        rdd_block_t prev;
        logic [5:0] err_count;
        logic [3:0] quality;
        logic overflow;
        logic reset_seen;
        logic data_ready_n;
        // first block of a pair seen, reduced rate protocol
        logic pair_half;
        logic qtrig;
        logic resync;
        // restart requested, pulsed on the next cycle
        logic resync_pend;
    } rdd_state_t;

    // the reset-detected flag comes up set, and one restart is pending
    localparam rdd_state_t S_RESET = '{
        mode_wr: MODE_RESET,
        mode_act: MODE_RESET,
        pause: PAUSE_RESET,
        osc: OSC_RESET,
        reset_seen: 1'b1,
        data_ready_n: 1'b1,
        resync_pend: 1'b1,
        default: '0
    };

    rdd_state_t s;
    rdd_state_t next_s;
    // head of the block buffer
    logic buf_valid;
    rdd_block_t buf_blk;
    logic load;

    // ----------------------------------------------------------------
    // read byte selection
    // ----------------------------------------------------------------
    // pointer 7 is past the last byte and reads zero
    function automatic logic [BYTE_W-1:0] read_byte(
        input logic [2:0] ptr,
        input rdd_state_t st,
        input logic synced
    );
        unique case (ptr)
            RD_STATUS: read_byte = {st.last.id, synced, st.overflow,
                                    st.reset_seen, st.last.err};
            RD_LAST_HI: read_byte = st.last.word[15:8];
            RD_LAST_LO: read_byte = st.last.word[7:0];
            RD_PREV_HI: read_byte = st.prev.word[15:8];
            RD_PREV_LO: read_byte = st.prev.word[7:0];
            RD_ERRORS: read_byte = {st.err_count, st.prev.err};
            RD_QUALITY: read_byte = {st.prev.id, 1'b0, st.quality};
            RD_END: read_byte = '0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // block buffer
    // ----------------------------------------------------------------
    // loading is held off for a whole read transfer so that one read
    // never mixes two blocks; a long read therefore fills the buffer
    assign load = buf_valid && !i_rd_active;

    rdd_fifo #(
        .WIDTH(BLOCK_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(i_blk_valid),
        .i_data(i_blk),
        .o_ready(o_blk_ready),
        .o_valid(buf_valid),
        .o_data(buf_blk),
        .i_ready(!i_rd_active)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.qtrig = 1'b0;
        next_s.resync = 1'b0;

        // a restart also clears the error count and block pairing
        if (s.resync_pend) begin
            next_s.resync = 1'b1;
            next_s.resync_pend = 1'b0;
            next_s.err_count = '0;
            next_s.pair_half = 1'b0;
        end

        // write transfer, bytes 0 to 2 in order
        if (i_wr_start) begin
            next_s.wr_ptr = WR_MODE;
        end else if (i_wr_strobe && s.wr_ptr != WR_END) begin
            unique case (s.wr_ptr)
                WR_MODE: begin
                    next_s.mode_wr = i_wr_byte;
                    next_s.qtrig = next_s.mode_wr.quality_trigger;
                    if (next_s.mode_wr.sync_restart) begin
                        next_s.resync_pend = 1'b1;
                    end
                end
                WR_PAUSE: next_s.pause = i_wr_byte;
                WR_OSC: next_s.osc = i_wr_byte;
                default: next_s.osc = s.osc;
            endcase
            next_s.wr_ptr = s.wr_ptr + WR_STEP;
        end

        // read transfer, bytes 0 to 6 in order
        // the status read clears the reset flag, the last low byte overflow
        if (i_rd_start) begin
            next_s.rd_ptr = RD_STATUS;
            next_s.data_ready_n = 1'b1;
        end else if (i_rd_strobe) begin
            next_s.rd_byte = read_byte(s.rd_ptr, s, i_synced);
            next_s.rd_valid = 1'b1;
            if (s.rd_ptr == RD_STATUS) begin
                next_s.reset_seen = 1'b0;
            end
            if (s.rd_ptr == RD_LAST_LO) begin
                next_s.overflow = 1'b0;
            end
            if (s.rd_ptr != RD_END) begin
                next_s.rd_ptr = s.rd_ptr + RD_STEP;
            end
        end

        // quality result stands until the next measurement ends
        if (i_quality_valid) begin
            next_s.quality = i_quality_value;
        end

        // a dropped block sets the flag even while it is being cleared
        if (i_blk_valid && !o_blk_ready) begin
            next_s.overflow = 1'b1;
        end

        // pairs restart whenever sync is regained
        if (!i_synced) begin
            next_s.pair_half = 1'b0;
        end

        // the decision below still uses the mode of the previous block;
        // a new mode takes effect from the following block
        if (load) begin
            next_s.prev = s.last;
            next_s.last = buf_blk;
            next_s.mode_act = s.mode_wr;
            if (buf_blk.err == ERR_UNCORRECTABLE &&
                s.err_count != ERR_COUNT_MAX) begin
                next_s.err_count = s.err_count + ERR_COUNT_STEP;
            end
            if (i_synced) begin
                unique case (s.mode_act.output_protocol)
                    PROTOCOL_STANDARD,
                    PROTOCOL_FAST_ID_SEARCH: begin
                        next_s.data_ready_n = 1'b0;
                    end
                    PROTOCOL_REDUCED_RATE: begin
                        next_s.pair_half = !s.pair_half;
                        if (s.pair_half) begin
                            next_s.data_ready_n = 1'b0;
                        end
                    end
                    default: next_s.data_ready_n = s.data_ready_n;
                endcase
            end else if (s.mode_act.output_protocol ==
                         PROTOCOL_FAST_ID_SEARCH &&
                         buf_blk.id == BLK_A &&
                         buf_blk.err == ERR_NONE) begin
                next_s.data_ready_n = 1'b0;
            end
        end else if (!i_synced) begin
            // without blocks, new settings still reach the search logic
            next_s.mode_act = s.mode_wr;
        end

        // no data is offered during search, except by the fast search mode
        if (!i_synced && s.mode_act.output_protocol !=
            PROTOCOL_FAST_ID_SEARCH) begin
            next_s.data_ready_n = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= S_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // acknowledge is a hint only; the framing layer builds the bit
    assign o_wr_ack = (s.wr_ptr != WR_END);
    assign o_rd_byte = s.rd_byte;
    assign o_rd_valid = s.rd_valid;
    assign o_mode = s.mode_act;
    assign o_pause = s.pause;
    assign o_osc = s.osc;
    assign o_quality_trigger = s.qtrig;
    assign o_sync_restart = s.resync;
    // idles high, so a polling controller sees no false request
    assign o_data_ready_n = s.data_ready_n;

endmodule // rdd_regs

`default_nettype wire

// ===== test/rdd_regs_monitor.sv
// Purpose: concurrent checks on the register set ports
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the ports of rdd_regs, attached by bind
`timescale 1ns/1ps
`default_nettype none
module rdd_regs_monitor
    import rdd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_wr_start,
    input wire logic i_wr_strobe,
    input wire logic [BYTE_W-1:0] i_wr_byte,
    input wire logic o_wr_ack,
    input wire logic i_rd_start,
    input wire logic i_rd_active,
    input wire logic i_rd_strobe,
    input wire logic [BYTE_W-1:0] o_rd_byte,
    input wire logic o_rd_valid,
    input wire logic i_blk_valid,
    input wire rdd_block_t i_blk,
    input wire logic o_blk_ready,
    input wire logic i_synced,
    input wire logic i_quality_valid,
    input wire logic [3:0] i_quality_value,
    input wire rdd_mode_t o_mode,
    input wire rdd_pause_t o_pause,
    input wire rdd_osc_t o_osc,
    input wire logic o_quality_trigger,
    input wire logic o_sync_restart,
    input wire logic o_data_ready_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_write3;
        i_wr_start ##1 i_wr_strobe [*3];
    endsequence
    sequence s_trig_cause;
        $past(i_wr_strobe) && $past(i_wr_byte[6]);
    endsequence
    property p_rd_valid; i_rd_strobe |=> o_rd_valid; endproperty
    property p_rd_pulse; !i_rd_strobe |=> !o_rd_valid; endproperty
    property p_ack_start; i_wr_start |=> o_wr_ack; endproperty
    property p_ack_drop; s_write3 |=> !o_wr_ack; endproperty
    property p_trig_cause; o_quality_trigger |-> s_trig_cause; endproperty
    property p_trig_pulse; o_quality_trigger |=> !o_quality_trigger; endproperty
    property p_restart_pulse; o_sync_restart |=> !o_sync_restart; endproperty
    property p_dr_clear; i_rd_start |=> o_data_ready_n; endproperty
    // only the fast search protocol may signal data while unsynced
    property p_dr_search;
        $fell(o_data_ready_n) |-> i_synced || $past(i_synced)
            || $past(i_synced, 2)
            || o_mode.output_protocol == PROTOCOL_FAST_ID_SEARCH;
    endproperty

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_rd_valid: assert property (p_rd_valid)
        else $error("read strobe without read valid");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read valid without strobe");
    a_ack_start: assert property (p_ack_start)
        else $error("write start did not rearm acknowledge");
    a_ack_drop: assert property (p_ack_drop)
        else $error("fourth write byte acknowledged");
    a_trig_cause: assert property (p_trig_cause)
        else $error("quality trigger without written bit");
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("quality trigger longer than one cycle");
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("sync restart longer than one cycle");
    a_dr_clear: assert property (p_dr_clear)
        else $error("data ready not released by read start");
    a_dr_search: assert property (p_dr_search)
        else $error("data ready fell during sync search");
endmodule // rdd_regs_monitor

bind rdd_regs rdd_regs_monitor #(.DEPTH(DEPTH)) u_mon (.i_clk, .i_arst_n,
    .i_wr_start, .i_wr_strobe, .i_wr_byte, .o_wr_ack, .i_rd_start,
    .i_rd_active, .i_rd_strobe, .o_rd_byte, .o_rd_valid, .i_blk_valid,
    .i_blk, .o_blk_ready, .i_synced, .i_quality_valid, .i_quality_value,
    .o_mode, .o_pause, .o_osc, .o_quality_trigger, .o_sync_restart,
    .o_data_ready_n);
`default_nettype wire

// ===== test/rdd_block_source.sv
// Purpose: block detector stand-in feeding decoded blocks
// Assumes: blocks arrive at a fixed bit rate and cannot wait
// Notes: no stalling, so a full buffer loses the offered block
`timescale 1ns/1ps
`default_nettype none
module rdd_block_source
    import rdd_pkg::*;
(
    input wire logic i_clk,
    output logic o_valid,
    output rdd_block_t o_blk
);
    initial begin
        o_valid = 1'b0;
        o_blk = '0;
    end
    // one-cycle offer: the air stream does not pause for a busy reader
    task send(input logic [15:0] w, input logic [2:0] id, input logic [1:0] e);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_blk <= {w, id, e};
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_blk <= ~{w, id, e};
        @(posedge i_clk);
    endtask
endmodule // rdd_block_source
`default_nettype wire

// ===== test/rdd_regs_bench.sv
// Purpose: self-checking bench for the register set
// Assumes: 20 MHz clock, buffer depth 8
// Notes: drives at rising edges, samples 1 ns later
`timescale 1ns/1ps
`default_nettype none
module rdd_regs_bench;
    import rdd_pkg::*;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr_start = 1'b0, i_wr_strobe = 1'b0;
    logic [7:0] i_wr_byte = 8'h00;
    logic i_rd_start = 1'b0, i_rd_active = 1'b0, i_rd_strobe = 1'b0;
    logic i_synced = 1'b0, i_quality_valid = 1'b0;
    logic [3:0] i_quality_value = 4'h0;
    logic blk_valid, o_wr_ack, o_rd_valid, o_blk_ready, o_quality_trigger;
    logic o_sync_restart, o_data_ready_n;
    logic [7:0] o_rd_byte, m;
    rdd_block_t blk;
    rdd_mode_t o_mode;
    rdd_pause_t o_pause;
    rdd_osc_t o_osc;
    logic [7:0] rb [0:6];
    int n_trig = 0, n_rst = 0, t0 = 0, r0 = 0;
    logic [1:0] c;
    int failures = 0, n_compared = 0;

    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_quality_trigger === 1'b1) n_trig <= n_trig + 1;
        if (o_sync_restart === 1'b1) n_rst <= n_rst + 1;
    end

    rdd_regs #(.DEPTH(8)) DUT (.i_clk, .i_arst_n, .i_wr_start, .i_wr_strobe,
        .i_wr_byte, .o_wr_ack, .i_rd_start, .i_rd_active, .i_rd_strobe,
        .o_rd_byte, .o_rd_valid, .i_blk_valid(blk_valid), .i_blk(blk),
        .o_blk_ready, .i_synced, .i_quality_valid, .i_quality_value, .o_mode,
        .o_pause, .o_osc, .o_quality_trigger, .o_sync_restart, .o_data_ready_n);
    rdd_block_source src (.i_clk, .o_valid(blk_valid), .o_blk(blk));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // a fourth byte follows every write and must be refused
    task wr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        @(posedge i_clk);
        i_wr_start <= 1'b1;
        @(posedge i_clk);
        i_wr_start <= 1'b0;
        i_wr_strobe <= 1'b1;
        i_wr_byte <= b0;
        @(posedge i_clk);
        i_wr_byte <= b1;
        @(posedge i_clk);
        i_wr_byte <= b2;
        @(posedge i_clk);
        i_wr_byte <= ~b2;
        @(posedge i_clk);
        i_wr_strobe <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task rd_all;
        @(posedge i_clk);
        i_rd_start <= 1'b1;
        i_rd_active <= 1'b1;
        @(posedge i_clk);
        i_rd_start <= 1'b0;
        i_rd_strobe <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            @(posedge i_clk);
            if (k == 6) i_rd_strobe <= 1'b0;
            #1;
            chk(o_rd_valid, 1'b1);
            rb[k] = o_rd_byte;
        end
        @(posedge i_clk);
        i_rd_active <= 1'b0;
        #1;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk(o_mode, MODE_RESET);
        chk(o_pause, 8'h20);
        chk(o_osc, 8'h0F);
        chk(16'(n_rst), 16'h0001);
        rd_all;
        chk(rb[0][2], 1'b1);
        rd_all;
        chk(rb[0][2], 1'b0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            m = {c[0], 1'b1, 1'b0, c, c[1], c};
            t0 = n_trig;
            r0 = n_rst;
            wr(m, {c, 6'(i * 21)}, {c, c[0], 5'(i * 10 + 1)});
            chk(o_mode & 8'h9F, m & 8'h9F);
            chk(o_pause, {c, 6'(i * 21)});
            chk(o_osc, {c, c[0], 5'(i * 10 + 1)});
            chk(o_wr_ack, 1'b0);
            chk({8'(n_trig - t0), 8'(n_rst - r0)}, 16'h0100);
        end
        t0 = n_trig;
        r0 = n_rst;
        wr(8'h20, 8'h00, 8'h00);
        chk({8'(n_trig - t0), 8'(n_rst - r0)}, 16'h0001);
        $display("test writes done");
        @(posedge i_clk);
        i_synced <= 1'b1;
        i_quality_valid <= 1'b1;
        i_quality_value <= 4'h9;
        @(posedge i_clk);
        i_quality_valid <= 1'b0;
        src.send(16'h1234, BLK_B, ERR_NONE);
        src.send(16'hABCD, BLK_D, ERR_UNCORRECTABLE);
        repeat (5) @(posedge i_clk);
        #1;
        chk(o_data_ready_n, 1'b0);
        rd_all;
        chk(rb[0], {BLK_D, 1'b1, 1'b0, 1'b0, ERR_UNCORRECTABLE});
        chk({rb[1], rb[2]}, 16'hABCD);
        chk({rb[3], rb[4]}, 16'h1234);
        chk(rb[5], {6'h01, ERR_NONE});
        chk(rb[6] & 8'hEF, {BLK_B, 1'b0, 4'h9});
        chk(o_data_ready_n, 1'b1);
        $display("test blocks done");
        @(posedge i_clk);
        i_rd_active <= 1'b1;
        for (int k = 1; k <= 10; k++) src.send(16'h0100 + 16'(k), BLK_A, ERR_NONE);
        #1;
        chk(o_blk_ready, 1'b0);
        @(posedge i_clk);
        i_rd_active <= 1'b0;
        repeat (40) @(posedge i_clk);
        rd_all;
        chk(rb[0][3], 1'b1);
        chk({rb[1], rb[2]}, 16'h0108);
        chk({rb[3], rb[4]}, 16'h0107);
        rd_all;
        chk(rb[0][3], 1'b0);
        $display("test overflow done");
        // reduced rate: data ready after every second block only
        @(posedge i_clk);
        i_synced <= 1'b0;
        wr(8'h02, 8'h20, 8'h0F);
        @(posedge i_clk);
        i_synced <= 1'b1;
        src.send(16'h0201, BLK_A, ERR_NONE);
        #1;
        chk(o_data_ready_n, 1'b1);
        src.send(16'h0202, BLK_B, ERR_NONE);
        #1;
        chk(o_data_ready_n, 1'b0);
        // fast search: only a clean A block gives data ready unsynced
        @(posedge i_clk);
        i_synced <= 1'b0;
        wr(8'h01, 8'h20, 8'h0F);
        src.send(16'h0301, BLK_B, ERR_NONE);
        #1;
        chk(o_data_ready_n, 1'b1);
        src.send(16'h0302, BLK_A, ERR_NONE);
        #1;
        chk(o_data_ready_n, 1'b0);
        $display("test protocols done");
        report_and_stop;
    end

    initial begin
        #(50 * 3000);
        failures++;
        report_and_stop;
    end
endmodule // rdd_regs_bench
`default_nettype wire
